// >>> logic/stmc_pkg.sv
// package for the standard timer mode control block
package stmc_pkg;
   // register byte addresses (no offsets given, chosen here)
   localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RUN_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO    = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI    = 8'h0C;
   localparam logic [7:0] ADDR_CMPA_LO   = 8'h10;
   localparam logic [7:0] ADDR_CMPA_HI   = 8'h14;
   localparam logic [7:0] ADDR_CAPT_LO   = 8'h18;
   localparam logic [7:0] ADDR_CAPT_HI   = 8'h1C;
   // widths and reset values
   localparam int CNT_W = 10;
   localparam int CMPP_W = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   // run control fields
   localparam int RUN_ON_BIT = 3;
   // operating modes
   localparam logic [1:0] MODE_CMP  = 2'h0;
   localparam logic [1:0] MODE_CAPT = 2'h1;
   localparam logic [1:0] MODE_PWM  = 2'h2;
   localparam logic [1:0] MODE_TMR  = 2'h3;
   // pin function codes
   localparam logic [1:0] PF_0 = 2'h0;
   localparam logic [1:0] PF_1 = 2'h1;
   localparam logic [1:0] PF_2 = 2'h2;
   localparam logic [1:0] PF_3 = 2'h3;
   // mode/output control register layout
   typedef struct packed {
      logic [1:0] mode_sel;
      logic [1:0] pin_function;
      logic       output_level_control;
      logic       output_polarity;
      logic       duty_period_swap;
      logic       clear_select;
   } stmc_ctrl_t;
   // single pulse states
   typedef enum logic [1:0] {SP_IDLE, SP_ACTIVE, SP_DONE} stmc_sp_t;
endpackage

// >>> logic/stmc_timer.sv
// standard timer mode control: registers, counter, compare, capture, output pin
`timescale 1ns/10ps
// Functional notes
// [RQ1] mode field: 00 compare, 01 capture, 10 pwm/single pulse, 11 timer
// [RQ2] software turns timer off before changing mode field
// [RQ3] timer/counter mode: output pin not driven by timer, pin function unused
// [RQ4] compare mode on match A: 00 none, 01 low, 10 high, 11 toggle
// [RQ5] pwm mode pin function: 00 inactive, 01 active, 10 pwm, 11 single pulse
// [RQ6] capture mode: 00 rising, 01 falling, 10 both edges, 11 disabled
// [RQ7] requested level equal to initial level gives no visible change
// [RQ8] on/off rising edge returns compare output to its initial level
// [RQ9] software changes pin function in pwm mode only while timer off
// [RQ10] compare mode: output control bit gives initial pin level
// [RQ11] pwm mode: output control bit selects active high or low
// [RQ12] single pulse: output control bit gives level at on/off rise
// [RQ13] output control bit has no effect in timer/counter mode
// [RQ14] polarity bit inverts output pin, no effect in timer mode
// [RQ15] swap bit 0: P period, A duty; 1: reversed
// [RQ16] clear select 1: match A clears; 0: match P or overflow clears
// [RQ17] overflow clear only when compare P value is zero
// [RQ18] clear select ignored in pwm, single pulse and capture modes
// [RQ19] counter read only, split low byte and two-bit high byte
// [RQ20] compare A value read/write, split low and high byte
// [RQ21] on/off rise zeroes counter; fall stops and holds counter
// [RQ22] compare P matches counter bits 9..7; 000 means 1024 clocks
// [RQ23] pwm is mode 10 pin 10; single pulse mode 10 pin 11
// [RQ24] polarity inversion is final stage before output pin
module stmc_timer
   import stmc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // pins
   input  wire logic        capture_input_pin,
   output logic             timer_output_pin,
   output logic             timer_output_pin_oe_n
);

   // registers
   stmc_ctrl_t           ctrl_r;
   logic [7:0]           run_ctrl_r;
   logic [CNT_W-1:0]     cnt_r;
   logic [CNT_W-1:0]     cmpa_r;
   logic [CNT_W-1:0]     capt_r;
   logic                 on_d_r;
   logic                 out_r;
   logic                 pin_s1_r;
   logic                 pin_s2_r;
   logic                 pin_s3_r;
   stmc_sp_t             sp_r;
   logic                 pready_r;
   logic [31:0]          prdata_r;
   logic                 pslverr_r;
   logic                 pin_r;
   logic                 oe_n_r;

   logic                 timer_on;
   logic                 on_rise;
   logic                 match_a;
   logic                 match_p;
   logic                 overflow;
   logic                 cnt_clear;
   logic [CNT_W:0]       period;
   logic [CNT_W:0]       duty;
   logic                 pwm_active;
   logic                 cap_evt;
   logic                 level_pre;
   logic                 wr_acc;
   logic                 rd_acc;
   logic [2:0]           cmpp;

   // pad a byte into the read word
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   // 3-bit P value in counts; zero stands for full 1024
   function automatic logic [CNT_W:0] p_span(input logic [2:0] p);
      p_span = (p == 3'h0) ? {1'b1, 10'h000} : {1'b0, p, 7'h00};
   endfunction

   assign cmpp     = run_ctrl_r[2:0];
   assign timer_on = run_ctrl_r[RUN_ON_BIT];
   assign on_rise  = timer_on & ~on_d_r;
   assign wr_acc   = psel & penable & pwrite;
   assign rd_acc   = psel & penable & ~pwrite;

   // comparators: P matches the top three counter bits, with the low seven bits zero
   assign match_a  = timer_on & (cnt_r == cmpa_r);
   assign match_p  = timer_on & (cmpp != 3'h0) & (cnt_r[9:7] == cmpp) &
                     (cnt_r[6:0] == 7'h00);                                // RQ22
   assign overflow = timer_on & (cmpp == 3'h0) & (cnt_r == CNT_MAX);       // RQ17

   // pwm period and duty, roles swapped by the swap bit
   always_comb begin
      if (ctrl_r.duty_period_swap) begin                                   // RQ15
         period = {1'b0, cmpa_r};
         duty   = p_span(cmpp);
      end else begin
         period = p_span(cmpp);
         duty   = {1'b0, cmpa_r};
      end
   end

   // clear source; pwm/capture modes ignore the clear select bit
   always_comb begin
      case (ctrl_r.mode_sel)
         MODE_CMP, MODE_TMR:
            cnt_clear = ctrl_r.clear_select ? match_a                      // RQ16
                        : (match_p | overflow);
         MODE_PWM:                                                         // RQ18
            cnt_clear = timer_on & ({1'b0, cnt_r} + 11'h001 >= period);
         default:
            cnt_clear = match_p | overflow;                                // RQ18
      endcase
   end

   // counter: rise zeroes, off holds residual value
   always_ff @(posedge clk) begin
      if (rst)
         cnt_r <= '0;
      else if (on_rise)
         cnt_r <= '0;                                                      // RQ21
      else if (timer_on)
         cnt_r <= cnt_clear ? '0 : cnt_r + 10'h001;
   end

   // clear by P match in compare mode; pwm wraps at its period whatever the select bit
   a_clear_p: assert property (@(posedge clk) disable iff (rst) // RQ16 RQ22
      ctrl_r.mode_sel == MODE_CMP && !ctrl_r.clear_select && match_p
      |=> cnt_r == '0) else $error("match P did not clear");
   a_pwm_wrap: assert property (@(posedge clk) disable iff (rst) // RQ15 RQ18
      ctrl_r.mode_sel == MODE_PWM && timer_on && ({1'b0, cnt_r} + 11'h001 >= period)
      |=> cnt_r == '0) else $error("pwm period not kept");

   // on/off edge history
   always_ff @(posedge clk) begin
      if (rst)
         on_d_r <= 1'b0;
      else
         on_d_r <= timer_on;
   end

   // capture pin synchroniser plus edge history stage
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= capture_input_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // capture edge selection
   always_comb begin
      case (ctrl_r.pin_function)
         PF_0:    cap_evt = pin_s2_r & ~pin_s3_r;                          // RQ6
         PF_1:    cap_evt = ~pin_s2_r & pin_s3_r;
         PF_2:    cap_evt = pin_s2_r ^ pin_s3_r;
         default: cap_evt = 1'b0;
      endcase
   end

   // capture register holds counter at the selected edge
   always_ff @(posedge clk) begin
      if (rst)
         capt_r <= '0;
      else if (timer_on && ctrl_r.mode_sel == MODE_CAPT && cap_evt)
         capt_r <= cnt_r;                                                  // RQ6
   end

   // disabled capture never moves the register; rising edge takes the counter
   a_capt_off: assert property (@(posedge clk) disable iff (rst) // RQ6
      ctrl_r.mode_sel == MODE_CAPT && ctrl_r.pin_function == PF_3
      |=> $stable(capt_r)) else $error("capture while disabled");
   a_capt_rise: assert property (@(posedge clk) disable iff (rst) // RQ6
      ctrl_r.mode_sel == MODE_CAPT && ctrl_r.pin_function == PF_0 && timer_on &&
      pin_s2_r && !pin_s3_r |=> capt_r == $past(cnt_r)) else $error("rising edge missed");

   // pwm active phase: counter below duty
   assign pwm_active = ({1'b0, cnt_r} < duty);

   // single pulse: one active phase after on/off rise, ends on match A
   always_ff @(posedge clk) begin
      if (rst)
         sp_r <= SP_IDLE;
      else if (on_rise)
         sp_r <= SP_ACTIVE;                                                // RQ12
      else begin
         case (sp_r)
            SP_ACTIVE: if (match_a || !timer_on) sp_r <= SP_DONE;
            SP_DONE:   sp_r <= SP_DONE;
            default:   sp_r <= SP_IDLE;
         endcase
      end
   end

   // pulse starts with every on/off rise and ends at the first A match
   a_sp_start: assert property (@(posedge clk) disable iff (rst) // RQ12
      on_rise |=> sp_r == SP_ACTIVE) else $error("pulse not started");
   a_sp_end: assert property (@(posedge clk) disable iff (rst) // RQ12
      sp_r == SP_ACTIVE && match_a && !on_rise |=> sp_r == SP_DONE)
      else $error("pulse not ended");

   // compare-mode output level; initial level reloaded on on/off rise
   always_ff @(posedge clk) begin
      if (rst)
         out_r <= 1'b0;
      else if (on_rise)
         out_r <= ctrl_r.output_level_control;                             // RQ8 RQ10
      else if (ctrl_r.mode_sel == MODE_CMP && match_a) begin
         case (ctrl_r.pin_function)                                        // RQ4
            PF_1:    out_r <= 1'b0;                                        // RQ7
            PF_2:    out_r <= 1'b1;
            PF_3:    out_r <= ~out_r;
            default: out_r <= out_r;
         endcase
      end
   end

   // match drives low, or leaves the level alone at code 00
   a_cmp_low: assert property (@(posedge clk) disable iff (rst) // RQ4
      ctrl_r.mode_sel == MODE_CMP && match_a && !on_rise && ctrl_r.pin_function == PF_1
      |=> !out_r) else $error("match did not drive low");
   a_cmp_hold: assert property (@(posedge clk) disable iff (rst) // RQ4 RQ7
      ctrl_r.mode_sel == MODE_CMP && match_a && !on_rise && ctrl_r.pin_function == PF_0
      |=> $stable(out_r)) else $error("level changed without request");

   // level before polarity, chosen by mode
   always_comb begin
      case (ctrl_r.mode_sel)                                               // RQ1
         MODE_CMP:  level_pre = out_r;
         MODE_PWM: begin
            // active state mapped through output control bit
            case (ctrl_r.pin_function)                                     // RQ5 RQ23
               PF_0:    level_pre = ~ctrl_r.output_level_control;          // RQ11
               PF_1:    level_pre = ctrl_r.output_level_control;
               PF_2:    level_pre = pwm_active ? ctrl_r.output_level_control
                                    : ~ctrl_r.output_level_control;        // RQ11
               default: level_pre = (sp_r == SP_ACTIVE) ?
                                    ctrl_r.output_level_control
                                    : ~ctrl_r.output_level_control;        // RQ12
            endcase
         end
         default:   level_pre = 1'b0;
      endcase
   end

   // forced pwm levels follow the active-level bit
   a_pwm_inact: assert property (@(posedge clk) disable iff (rst) // RQ5 RQ11
      ctrl_r.mode_sel == MODE_PWM && ctrl_r.pin_function == PF_0
      |-> level_pre == ~ctrl_r.output_level_control) else $error("inactive level wrong");
   a_pwm_act: assert property (@(posedge clk) disable iff (rst) // RQ5 RQ11
      ctrl_r.mode_sel == MODE_PWM && ctrl_r.pin_function == PF_1
      |-> level_pre == ctrl_r.output_level_control) else $error("active level wrong");

   // output pin: polarity last; timer mode releases the pin
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_r  <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         pin_r  <= level_pre ^ ctrl_r.output_polarity;                     // RQ14 RQ24
         oe_n_r <= (ctrl_r.mode_sel == MODE_TMR) ||
                   (ctrl_r.mode_sel == MODE_CAPT);                         // RQ3 RQ13
      end
   end

   // output modes drive the pin
   a_cmp_drive: assert property (@(posedge clk) disable iff (rst) // RQ10
      ctrl_r.mode_sel == MODE_CMP |=> !oe_n_r) else $error("compare pin released");

   // software-written registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r     <= stmc_ctrl_t'(RST_BYTE);
         run_ctrl_r <= RST_BYTE;
         cmpa_r     <= '0;
      end else if (wr_acc) begin
         case (paddr)
            ADDR_MODE_CTRL: ctrl_r <= stmc_ctrl_t'(pwdata[7:0]);           // RQ1
            ADDR_RUN_CTRL:  run_ctrl_r <= pwdata[7:0];
            ADDR_CMPA_LO:   cmpa_r[7:0] <= pwdata[7:0];                    // RQ20
            ADDR_CMPA_HI:   cmpa_r[9:8] <= pwdata[1:0];                    // RQ20
            default: ;
         endcase
      end
   end

   // compare A low byte lands as written
   a_cmpa_write: assert property (@(posedge clk) disable iff (rst) // RQ20
      wr_acc && paddr == ADDR_CMPA_LO |=> cmpa_r[7:0] == $past(pwdata[7:0]))
      else $error("compare A write lost");

   // apb answer: zero-wait, registered, unmapped gives pslverr
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= psel & ~penable;
         pslverr_r <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               ADDR_MODE_CTRL: prdata_r <= byte_word(ctrl_r);
               ADDR_RUN_CTRL:  prdata_r <= byte_word(run_ctrl_r);
               ADDR_CNT_LO:    prdata_r <= byte_word(cnt_r[7:0]);          // RQ19
               ADDR_CNT_HI:    prdata_r <= byte_word({6'h00, cnt_r[9:8]}); // RQ19
               ADDR_CMPA_LO:   prdata_r <= byte_word(cmpa_r[7:0]);         // RQ20
               ADDR_CMPA_HI:   prdata_r <= byte_word({6'h00, cmpa_r[9:8]});
               ADDR_CAPT_LO:   prdata_r <= byte_word(capt_r[7:0]);
               ADDR_CAPT_HI:   prdata_r <= byte_word({6'h00, capt_r[9:8]});
               default: begin
                  prdata_r  <= '0;
                  pslverr_r <= 1'b1;
               end
            endcase
         end
      end
   end

   assign pready                = pready_r;
   assign prdata                = prdata_r;
   assign pslverr               = pslverr_r;
   assign timer_output_pin      = pin_r;
   assign timer_output_pin_oe_n = oe_n_r;

   // unused write bits of the bus are intentionally ignored
   logic unused_bits;
   assign unused_bits = rd_acc & (|pwdata[31:8]);

   // assertions
   a_on_rise_zero: assert property (@(posedge clk) disable iff (rst) // RQ21
      on_rise |=> cnt_r == '0) else $error("counter not zeroed");
   a_off_holds_cnt: assert property (@(posedge clk) disable iff (rst) // RQ21
      !timer_on && !wr_acc |=> $stable(cnt_r)) else $error("counter moved");
   a_init_level: assert property (@(posedge clk) disable iff (rst) // RQ8
      on_rise |=> out_r == $past(ctrl_r.output_level_control))
      else $error("initial level wrong");
   a_cmp_high: assert property (@(posedge clk) disable iff (rst) // RQ4
      ctrl_r.mode_sel == MODE_CMP && match_a && !on_rise && ctrl_r.pin_function == PF_2
      |=> out_r) else $error("match did not drive high");
   a_cmp_toggle: assert property (@(posedge clk) disable iff (rst) // RQ4
      ctrl_r.mode_sel == MODE_CMP && match_a && !on_rise && ctrl_r.pin_function == PF_3
      |=> out_r != $past(out_r)) else $error("toggle missed");
   a_timer_release: assert property (@(posedge clk) disable iff (rst) // RQ3
      ctrl_r.mode_sel == MODE_TMR |=> oe_n_r) else $error("pin driven");
   a_polarity_last: assert property (@(posedge clk) disable iff (rst) // RQ14
      1'b1 |=> pin_r == ($past(level_pre) ^ $past(ctrl_r.output_polarity)))
      else $error("polarity stage wrong");
   a_cnt_hi_zero: assert property (@(posedge clk) disable iff (rst) // RQ19
      psel && !penable && paddr == ADDR_CNT_HI |=> prdata_r[31:2] == '0)
      else $error("high bits not zero");
   a_clear_a: assert property (@(posedge clk) disable iff (rst) // RQ16
      ctrl_r.mode_sel == MODE_CMP && ctrl_r.clear_select && match_a && !on_rise
      |=> cnt_r == '0) else $error("match A did not clear");
   // read path: low byte carries the counter, unused high bits stay zero
   a_cnt_lo_read: assert property (@(posedge clk) disable iff (rst) // RQ19
      psel && !penable && paddr == ADDR_CNT_LO |=> prdata_r[7:0] == $past(cnt_r[7:0]))
      else $error("counter read wrong");
   a_cmpa_hi_zero: assert property (@(posedge clk) disable iff (rst) // RQ20
      psel && !penable && paddr == ADDR_CMPA_HI |=> prdata_r[31:2] == '0)
      else $error("compare A high bits not zero");
endmodule

// >>> test/stmc_pins_model.sv
// far side model: capture pin source and load on the timer output pin
`timescale 1ns/10ps
module stmc_pins_model (
   // clock
   input  wire logic clk,
   // bench side
   input  wire logic drive_lvl,
   output logic      seen_lvl,
   // pin side
   input  wire logic tout,
   input  wire logic tout_oe_n,
   output logic      cap_pin
);
   logic last_r = 1'b0;
   // capture source follows the bench, edges only where a test asks
   assign cap_pin = drive_lvl;
   // remember the last driven level of the output wire
   always_ff @(posedge clk) begin
      if (!tout_oe_n) begin
         last_r <= tout;
      end
   end
   // no pull on the wire: once released it must not look like the last level
   assign seen_lvl = tout_oe_n ? ~last_r : tout;
endmodule

// >>> test/stmc_timer_tb.sv
// self-checking bench for the standard timer mode control block
`timescale 1ns/10ps
module stmc_timer_tb;
   import stmc_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic        tout, oe_n, cap_lvl, cap_pin, seen, err, oc, pol;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv, seed, r, c0;
   int          fails, compares, i, pf, cnt;

   stmc_timer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .capture_input_pin(cap_pin), .timer_output_pin(tout), .timer_output_pin_oe_n(oe_n));
   stmc_pins_model pins (.clk(clk), .drive_lvl(cap_lvl), .seen_lvl(seen), .tout(tout),
      .tout_oe_n(oe_n), .cap_pin(cap_pin));

   // bench clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // xorshift source with a fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // compare-mode level after one match, before polarity
   function automatic logic cmp_lvl(input int f, input logic o);
      return (f == 0) ? o : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : ~o;
   endfunction

   // control byte: mode, pin function, level, polarity, swap, clear select
   function automatic logic [31:0] ctl(input logic [1:0] m, input int f,
                                       input logic o, p, s, c);
      return {24'h0, m, f[1:0], o, p, s, c};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // only the watchdog ends a hung wait; the slave should answer in its first access cycle
      chk("pready wait", 32'h1, t);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // pin is one cycle behind its cause, so let a few edges pass first
   task automatic pin_is(input string what, input logic exp);
      cyc(3);
      @(negedge clk);
      chk(what, {31'h0, exp}, {31'h0, seen});
   endtask

   task automatic count_high(input int k);
      cnt = 0;
      repeat (k) begin
         @(negedge clk);
         cnt += (seen === 1'b1);
      end
   endtask

   // mode and pin function change only while the timer is stopped
   task automatic start(input logic [31:0] c, input logic [31:0] run);
      apb(1'b1, ADDR_RUN_CTRL, 32'h0);
      apb(1'b1, ADDR_MODE_CTRL, c);
      apb(1'b1, ADDR_RUN_CTRL, run);
   endtask

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      cyc(20000);
      fails++;
      give_verdict();
   end

   initial begin
      {psel, penable, pwrite, cap_lvl} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      compares = 0;
      seed = 32'h00018359;
      rst = 1'b1;
      cyc(6);
      rst <= 1'b0;
      for (i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", 32'h0, rdv);
      end
      apb(1'b1, 8'h20, 32'hFF);
      chk("unmapped err", 32'h1, {31'h0, err});
      for (i = 0; i < 4; i++) begin
         r = rnd();
         apb(1'b1, ADDR_CMPA_LO, {24'h0, r[7:0]});
         apb(1'b1, ADDR_CMPA_HI, {24'h0, r[15:8]});
         apb(1'b1, ADDR_CNT_HI, {24'h0, r[23:16]});
         apb(1'b0, ADDR_CMPA_LO, 32'h0);
         chk("cmpa low", {24'h0, r[7:0]}, rdv);
         apb(1'b0, ADDR_CMPA_HI, 32'h0);
         chk("cmpa high", {30'h0, r[9:8]}, rdv);
         apb(1'b0, ADDR_CNT_HI, 32'h0);
         chk("counter ro", 32'h0, rdv);
      end
      $display("test registers done");
      apb(1'b1, ADDR_CMPA_LO, 32'h28);
      apb(1'b1, ADDR_CMPA_HI, 32'h0);
      for (pf = 0; pf < 4; pf++) begin
         r = rnd();
         oc = r[0];
         pol = r[1];
         start(ctl(MODE_CMP, pf, oc, pol, 1'b0, 1'b1), 32'h8);
         pin_is("initial level", oc ^ pol);
         chk("driven", 32'h0, {31'h0, oe_n});
         cyc(50);
         pin_is("match level", cmp_lvl(pf, oc) ^ pol);
         apb(1'b0, ADDR_CNT_LO, 32'h0);
         chk("clear on a", 32'h1, {31'h0, rdv <= 32'h28});
         start(ctl(MODE_CMP, pf, oc, pol, 1'b0, 1'b1), 32'h8);
         pin_is("restart level", oc ^ pol);
      end
      $display("test compare done");
      start(ctl(MODE_CMP, 0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h9);
      cyc(200);
      apb(1'b0, ADDR_CNT_LO, 32'h0);
      chk("clear on p", 32'h1, {31'h0, rdv > 32'h28 && rdv < 32'h80});
      apb(1'b1, ADDR_RUN_CTRL, 32'h1);
      apb(1'b0, ADDR_CNT_LO, 32'h0);
      c0 = rdv;
      cyc(20);
      apb(1'b0, ADDR_CNT_LO, 32'h0);
      chk("counter held", c0, rdv);
      apb(1'b1, ADDR_RUN_CTRL, 32'h9);
      apb(1'b0, ADDR_CNT_LO, 32'h0);
      chk("counter zeroed", 32'h1, {31'h0, rdv < 32'h8});
      start(ctl(MODE_TMR, 3, 1'b1, 1'b1, 1'b0, 1'b0), 32'h8);
      cyc(3);
      chk("released", 32'h1, {31'h0, oe_n});
      $display("test counter done");
      for (i = 0; i < 16; i++) begin
         pf = i / 4;
         oc = i[1];
         pol = i[0];
         if (pf != 2) begin
            start(ctl(MODE_PWM, pf, oc, pol, 1'b0, 1'b0), 32'h8);
            pin_is("pwm level", ((pf == 0) ? ~oc : oc) ^ pol);
            if (pf == 3) begin
               cyc(60);
               pin_is("pulse end", ~oc ^ pol);
            end
         end
      end
      apb(1'b1, ADDR_CMPA_LO, 32'h20);
      start(ctl(MODE_PWM, 2, 1'b1, 1'b0, 1'b0, 1'b1), 32'h9);
      cyc(10);
      count_high(256);
      chk("duty a", 32'h40, cnt);
      apb(1'b1, ADDR_CMPA_LO, 32'hC8);
      start(ctl(MODE_PWM, 2, 1'b1, 1'b0, 1'b1, 1'b1), 32'h9);
      cyc(10);
      count_high(400);
      chk("duty p", 32'h100, cnt);
      $display("test pwm done");
      for (pf = 0; pf < 4; pf++) begin
         start(ctl(MODE_CAPT, pf, 1'b0, 1'b0, 1'b0, 1'b0), 32'h8);
         for (i = 0; i < 2; i++) begin
            apb(1'b0, ADDR_CAPT_LO, 32'h0);
            c0 = rdv;
            cap_lvl <= ~cap_lvl;
            cyc(8);
            apb(1'b0, ADDR_CAPT_LO, 32'h0);
            r = {31'h0, cap_lvl ? (pf != 1 && pf != 3) : (pf == 1 || pf == 2)};
            chk("capture", r, {31'h0, rdv != c0});
         end
      end
      $display("test capture done");
      give_verdict();
   end
endmodule
